// ---- prcr_regs.vh ----
// register map, field positions, reset values and timing constants of the rail config bank
`ifndef PRCR_REGS_VH
`define PRCR_REGS_VH

// ----------------------------------------------------------------
// register offsets on the serial control bus
// ----------------------------------------------------------------
`define PRCR_ADDR_LDO_TWO 8'h9A
`define PRCR_ADDR_LDO_THREE 8'h9B
`define PRCR_ADDR_BUCK_CTRL 8'h9C
`define PRCR_ADDR_PG_DELAY 8'h9D

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PRCR_SLEEP_MSB 7
`define PRCR_SLEEP_LSB 4
`define PRCR_NORMAL_MSB 3
`define PRCR_NORMAL_LSB 0
`define PRCR_MODE_THREE_BIT 5
`define PRCR_MODE_TWO_BIT 4
`define PRCR_MODE_ONE_BIT 3
`define PRCR_KILL_THREE_BIT 2
`define PRCR_KILL_TWO_BIT 1
`define PRCR_KILL_ONE_BIT 0
`define PRCR_BUCK_LIVE_MSB 5
`define PRCR_DLY_TWO_MSB 7
`define PRCR_DLY_TWO_LSB 5
`define PRCR_DLY_FOUR_MSB 4
`define PRCR_DLY_FOUR_LSB 2
`define PRCR_DLY_ONE_MSB 1
`define PRCR_DLY_ONE_LSB 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PRCR_RST_LDO_TWO 8'h00
`define PRCR_RST_LDO_THREE 8'h00
`define PRCR_RST_BUCK_CTRL 6'h00
`define PRCR_RST_PG_DELAY 8'h00

// target address on the serial bus; value is arbitrary
`define PRCR_DEV_ADDR 7'h2A

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PRCR_CLK_PERIOD_NS 5
`define PRCR_NS_PER_MS 1000000
`define PRCR_DLY_MS_0 7'h00
`define PRCR_DLY_MS_1 7'h05
`define PRCR_DLY_MS_2 7'h0A
`define PRCR_DLY_MS_3 7'h0F
`define PRCR_DLY_MS_4 7'h14
`define PRCR_DLY_MS_5 7'h32
`define PRCR_DLY_MS_6 7'h4B
`define PRCR_DLY_MS_7 7'h64

`endif

// ---- prcr_pg_timer.v ----
// power-good delay timer for one general-purpose output
`timescale 1ns/1ps
`default_nettype none
`include "prcr_regs.vh"

module prcr_pg_timer #(
  parameter [31:0] MS_CYCLES = `PRCR_NS_PER_MS / `PRCR_CLK_PERIOD_NS
)
(
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // rail status and configuration
  input wire rails_ok,
  input wire pg_duty,
  input wire [2:0] delay_code,
  // result
  output reg pg_reg
);

  reg [31:0] cnt_reg;
  reg [6:0] dly_ms;
  wire [31:0] target;

  // ----------------------------------------------------------------
  // delay table, milliseconds per code
  // ----------------------------------------------------------------
  always @*
  begin
    case (delay_code)
      3'h0: dly_ms = `PRCR_DLY_MS_0;
      3'h1: dly_ms = `PRCR_DLY_MS_1;
      3'h2: dly_ms = `PRCR_DLY_MS_2;
      3'h3: dly_ms = `PRCR_DLY_MS_3;
      3'h4: dly_ms = `PRCR_DLY_MS_4;
      3'h5: dly_ms = `PRCR_DLY_MS_5;
      3'h6: dly_ms = `PRCR_DLY_MS_6;
      default: dly_ms = `PRCR_DLY_MS_7;
    endcase
  end

  // 100 ms at the worst is far below 2^32 cycles
  assign target = {25'h0000000, dly_ms} * MS_CYCLES;

  // count from the moment the last rail is in regulation; any drop restarts
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 32'h00000000;
      pg_reg <= 1'b0;
    end
    else if (!rails_ok || !pg_duty)
    begin
      cnt_reg <= 32'h00000000; // other duties leave the delay unused
      pg_reg <= 1'b0;
    end
    else if (cnt_reg >= target)
    begin
      pg_reg <= 1'b1; // asserted only once the delay has run out
    end
    else
    begin
      cnt_reg <= cnt_reg + 32'h00000001;
    end
  end

endmodule
`default_nettype wire

// ---- prcr_rail_config.v ----
// serial-bus register bank for linear regulator codes, converter modes and power-good delays
//
// Operation
// (R1) second linear regulator: bits 7:4 sleep code, bits 3:0 normal code, read/write.
// (R2) third linear regulator: bits 7:4 sleep code, bits 3:0 normal code, read/write.
// (R3) bit 5 sets third converter mode; 1 is forced PWM, host never writes 0.
// (R4) bit 4 sets second converter mode: 0 automatic, 1 forced PWM.
// (R5) bit 3 sets first converter mode: 0 automatic, 1 forced PWM.
// (R6) bit 2 low forces third converter off whatever the enable pins say.
// (R7) bit 1 low forces second converter off whatever the enable pins say.
// (R8) bit 0 low forces first converter off whatever the enable pins say.
// (R9) outputs one, two, four: delay timed from last rail in regulation, then good.
// (R10) delay settings matter only for outputs on power-good duty.
// (R11) output two delay, bits 7:5: 0,5,10,15,20,50,75,100 ms.
// (R12) output four delay, bits 4:2: same eight-step table.
// (R13) output one delay, bits 1:0: 0,5,10,15 ms.
// (R14) each linear regulator drives sleep code in sleep mode, else normal code.
// (R15) buck control bits 7:6 read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "prcr_regs.vh"

module prcr_rail_config #(
  parameter [31:0] MS_CYCLES = `PRCR_NS_PER_MS / `PRCR_CLK_PERIOD_NS,
  parameter [8:0] CONV_PIN_SEL = 9'h088
)
(
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // serial control bus, open drain data
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // rail enable and sleep pins
  input wire [5:0] rail_enable_inputs,
  input wire ldo_two_sleep,
  input wire ldo_three_sleep,
  // regulation status and output duty, index 0 one, 1 two, 2 four
  input wire [2:0] rails_in_regulation,
  input wire [2:0] pg_duty,
  // linear regulator codes
  output reg [3:0] ldo_two_code,
  output reg [3:0] ldo_three_code,
  // converter control, index 0 first .. 2 third
  output reg [2:0] converter_mode,
  output reg [2:0] converter_enable,
  // power good outputs
  output wire general_output_one,
  output wire general_output_two,
  output wire general_output_four
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_AACK = 3'h2;
  localparam [2:0] ST_RX = 3'h3;
  localparam [2:0] ST_WACK = 3'h4;
  localparam [2:0] ST_TX = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;

  // register bank
  reg [7:0] ldo_two_reg;
  reg [7:0] ldo_three_reg;
  reg [5:0] buck_reg;
  reg [7:0] pg_delay_reg;

  // synchronisers: stage one is read only by stage two
  reg [15:0] sync1_reg;
  reg [15:0] sync2_reg;
  reg scl_d_reg;
  reg sda_d_reg;

  // bus engine
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  reg ptr_phase_reg;
  reg rw_reg;
  reg nack_reg;
  reg wr_pulse_reg;
  reg [7:0] wr_addr_reg;
  reg [7:0] wr_data_reg;
  reg [7:0] rd_data;

  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  wire [5:0] en_pins;
  wire [2:0] rails_ok;
  wire [8:0] delay_codes;

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  // every pin crosses in from outside, so all take two flops
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 16'h0003;
      sync2_reg <= 16'h0003;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= {pg_duty, rails_in_regulation, ldo_three_sleep, ldo_two_sleep, rail_enable_inputs, scl_in, sda_in};
      sync2_reg <= sync1_reg;
      scl_d_reg <= sync2_reg[1];
      sda_d_reg <= sync2_reg[0];
    end
  end

  assign sda_s = sync2_reg[0];
  assign scl_s = sync2_reg[1];
  assign en_pins = sync2_reg[7:2];
  assign rails_ok = sync2_reg[12:10];
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  // unmapped offsets read as zero
  always @*
  begin
    case (ptr_reg)
      `PRCR_ADDR_LDO_TWO: rd_data = ldo_two_reg; // (R1)
      `PRCR_ADDR_LDO_THREE: rd_data = ldo_three_reg; // (R2)
      `PRCR_ADDR_BUCK_CTRL: rd_data = {2'h0, buck_reg}; // (R15)
      `PRCR_ADDR_PG_DELAY: rd_data = pg_delay_reg;
      default: rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // serial bus target
  // ----------------------------------------------------------------
  // acks any byte to this address; pointer auto-increments per data byte
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      ptr_phase_reg <= 1'b0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      wr_pulse_reg <= 1'b0;
      sda_out <= 1'b0;
      if (bus_start)
      begin
        state_reg <= ST_ADDR; // repeated start is accepted anywhere
        bit_cnt_reg <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            sda_oe <= 1'b0;
          end
          ST_ADDR:
          begin
            if (scl_rise)
            begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_fall && bit_cnt_reg == 4'h8)
            begin
              if (shift_reg[7:1] == `PRCR_DEV_ADDR)
              begin
                sda_oe <= 1'b1;
                rw_reg <= shift_reg[0];
                state_reg <= ST_AACK;
              end
              else
              begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_AACK:
          begin
            if (scl_fall)
            begin
              bit_cnt_reg <= 4'h0;
              if (rw_reg)
              begin
                shift_reg <= rd_data;
                sda_oe <= ~rd_data[7];
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= ST_TX;
              end
              else
              begin
                sda_oe <= 1'b0;
                ptr_phase_reg <= 1'b1; // first write byte is the pointer
                state_reg <= ST_RX;
              end
            end
          end
          ST_RX:
          begin
            if (scl_rise)
            begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_fall && bit_cnt_reg == 4'h8)
            begin
              sda_oe <= 1'b1;
              state_reg <= ST_WACK;
              if (ptr_phase_reg)
              begin
                ptr_reg <= shift_reg;
                ptr_phase_reg <= 1'b0;
              end
              else
              begin
                wr_pulse_reg <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          ST_WACK:
          begin
            if (scl_fall)
            begin
              sda_oe <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_RX;
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (bit_cnt_reg == 4'h7)
              begin
                sda_oe <= 1'b0; // release for the controller's ack
                state_reg <= ST_RACK;
              end
              else
              begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_oe <= ~shift_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK:
          begin
            if (scl_rise)
            begin
              nack_reg <= sda_s;
            end
            else if (scl_fall)
            begin
              bit_cnt_reg <= 4'h0;
              if (nack_reg)
              begin
                state_reg <= ST_IDLE;
              end
              else
              begin
                shift_reg <= rd_data;
                sda_oe <= ~rd_data[7];
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= ST_TX;
              end
            end
          end
          default:
          begin
            state_reg <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ldo_two_reg <= `PRCR_RST_LDO_TWO;
      ldo_three_reg <= `PRCR_RST_LDO_THREE;
      buck_reg <= `PRCR_RST_BUCK_CTRL;
      pg_delay_reg <= `PRCR_RST_PG_DELAY;
    end
    else if (wr_pulse_reg)
    begin
      case (wr_addr_reg)
        `PRCR_ADDR_LDO_TWO: ldo_two_reg <= wr_data_reg; // (R1)
        `PRCR_ADDR_LDO_THREE: ldo_three_reg <= wr_data_reg; // (R2)
        // reserved upper bits are simply not stored
        `PRCR_ADDR_BUCK_CTRL: buck_reg <= wr_data_reg[`PRCR_BUCK_LIVE_MSB:0]; // (R15)
        `PRCR_ADDR_PG_DELAY: pg_delay_reg <= wr_data_reg; // (R11)
        default: ldo_two_reg <= ldo_two_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // linear regulator codes and converter control
  // ----------------------------------------------------------------
  // a sleep pin change switches the field on the third edge, after the two sync flops
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ldo_two_code <= 4'h0;
      ldo_three_code <= 4'h0;
      converter_mode <= 3'h0;
    end
    else
    begin
      ldo_two_code <= sync2_reg[8] ? ldo_two_reg[`PRCR_SLEEP_MSB:`PRCR_SLEEP_LSB] :
        ldo_two_reg[`PRCR_NORMAL_MSB:`PRCR_NORMAL_LSB]; // (R14) (R1)
      ldo_three_code <= sync2_reg[9] ? ldo_three_reg[`PRCR_SLEEP_MSB:`PRCR_SLEEP_LSB] :
        ldo_three_reg[`PRCR_NORMAL_MSB:`PRCR_NORMAL_LSB]; // (R14) (R2)
      // third converter has no automatic mode; 0 there is left to the host
      converter_mode[2] <= buck_reg[`PRCR_MODE_THREE_BIT]; // (R3)
      converter_mode[1] <= buck_reg[`PRCR_MODE_TWO_BIT]; // (R4)
      converter_mode[0] <= buck_reg[`PRCR_MODE_ONE_BIT]; // (R5)
    end
  end

  // kill bit low overrides whichever enable pin the converter is mapped to
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_conv
      always @(posedge mclk)
      begin
        if (!rst_n)
          converter_enable[gi] <= 1'b0;
        else
          converter_enable[gi] <= buck_reg[`PRCR_KILL_ONE_BIT + gi] & en_pins[CONV_PIN_SEL[3*gi +: 3]]; // (R6) (R7) (R8)
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // power-good delays
  // ----------------------------------------------------------------
  // output one has a two-bit field, its codes are the low half of the table
  assign delay_codes = {pg_delay_reg[`PRCR_DLY_FOUR_MSB:`PRCR_DLY_FOUR_LSB], // (R12)
                        pg_delay_reg[`PRCR_DLY_TWO_MSB:`PRCR_DLY_TWO_LSB], // (R11)
                        1'b0, pg_delay_reg[`PRCR_DLY_ONE_MSB:`PRCR_DLY_ONE_LSB]}; // (R13)

  wire [2:0] pg_vec;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_pg
      prcr_pg_timer #(
        .MS_CYCLES(MS_CYCLES)
      ) u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .rails_ok(rails_ok[gi]), // (R9)
        .pg_duty(sync2_reg[13 + gi]), // (R10)
        .delay_code(delay_codes[3*gi +: 3]),
        .pg_reg(pg_vec[gi])
      );
    end
  endgenerate

  // timer outputs are flops already
  assign general_output_one = pg_vec[0];
  assign general_output_two = pg_vec[1];
  assign general_output_four = pg_vec[2];

endmodule
`default_nettype wire

// ---- prcr_rail_config_props.sv ----
// assertion checker for the rail config register bank
`timescale 1ns/1ps
`default_nettype none
module prcr_rail_config_props #(
  parameter [31:0] MS_CYCLES = 32'h30D40
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins seen by the bank
  input wire logic sda_oe,
  input wire logic [5:0] rail_enable_inputs,
  input wire logic ldo_two_sleep,
  input wire logic ldo_three_sleep,
  input wire logic [2:0] rails_in_regulation,
  input wire logic [2:0] pg_duty,
  // outputs under check
  input wire logic [3:0] ldo_two_code,
  input wire logic [3:0] ldo_three_code,
  input wire logic [2:0] converter_mode,
  input wire logic [2:0] converter_enable,
  input wire logic general_output_one,
  input wire logic general_output_two,
  input wire logic general_output_four
);
  // ----------------------------------------------------------------
  // properties, one clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // pin checks assume the default pin map, converter n on pin n
  property p_pin_one; !rail_enable_inputs[0] [*4] |=> !converter_enable[0]; endproperty
  a_pin_one: assert property (p_pin_one) else $error("first converter on with pin low");
  property p_pin_three; (rail_enable_inputs[2] == 1'b0) [*5] |-> converter_enable[2] == 1'b0; endproperty
  a_pin_three: assert property (p_pin_three) else $error("third converter on with pin low");
  // modes only move when a bus write has just been acknowledged
  property p_mode; $changed(converter_mode) |-> $past(sda_oe); endproperty
  a_mode: assert property (p_mode) else $error("converter mode moved without a write");
  // a code moves on a write or a few clocks after its sleep pin toggled
  property p_two_code;
    $changed(ldo_two_code) |-> $past(sda_oe) || ($past(ldo_two_sleep, 2) != $past(ldo_two_sleep, 6));
  endproperty
  a_two_code: assert property (p_two_code) else $error("second regulator code moved alone");
  property p_three_code;
    $changed(ldo_three_code) |-> $past(sda_oe) || ($past(ldo_three_sleep, 2) != $past(ldo_three_sleep, 6));
  endproperty
  a_three_code: assert property (p_three_code) else $error("third regulator code moved alone");
  property p_pg_drop; !rails_in_regulation[1] [*4] |=> !general_output_two; endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("output two good without rails");
  property p_pg_rise; $rose(general_output_one) |-> $past(rails_in_regulation[0], 3) && $past(pg_duty[0], 3); endproperty
  a_pg_rise: assert property (p_pg_rise) else $error("output one good without its cause");
  property p_pg_fall; $fell(rails_in_regulation[0]) |-> ##[1:4] !general_output_one; endproperty
  a_pg_fall: assert property (p_pg_fall) else $error("output one good held after rail loss");
  property p_duty; !pg_duty[2] [*4] |=> !general_output_four; endproperty
  a_duty: assert property (p_duty) else $error("output four good while off duty");
  c_pg_two: cover property ($rose(general_output_two));
  c_fpwm: cover property ($rose(converter_mode[1]));
  c_sleep: cover property ($changed(ldo_two_code) && ldo_two_sleep);
endmodule
bind prcr_rail_config prcr_rail_config_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .mclk(mclk), .rst_n(rst_n), .sda_oe(sda_oe), .rail_enable_inputs(rail_enable_inputs),
  .ldo_two_sleep(ldo_two_sleep), .ldo_three_sleep(ldo_three_sleep), .rails_in_regulation(rails_in_regulation),
  .pg_duty(pg_duty), .ldo_two_code(ldo_two_code), .ldo_three_code(ldo_three_code),
  .converter_mode(converter_mode), .converter_enable(converter_enable), .general_output_one(general_output_one),
  .general_output_two(general_output_two), .general_output_four(general_output_four));
`default_nettype wire

// ---- prcr_host.sv ----
// serial-bus host model that drives the bank's control bus
`timescale 1ns/1ps
`default_nettype none
`include "prcr_regs.vh"
module prcr_host (
  // clock and resolved data line
  input wire logic mclk,
  input wire logic sda_line,
  // host-driven lines, data is open drain
  output var logic scl,
  output var logic sda_low
);
  // ----------------------------------------------------------------
  // bus cycle tasks
  // ----------------------------------------------------------------
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ten clocks per clock phase, well over the four the target needs
  task automatic h();
    repeat (5) @(posedge mclk);
    #1;
  endtask
  // one bit out and one back, sampled in the middle of the high phase
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    h();
    sda_low = !b;
    h();
    scl = 1'b1;
    h();
    r = sda_line;
    h();
  endtask
  // msb first, then a released ninth bit
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, ack);
  endtask
  // write, or pointer then repeated start and one read ended by no-ack
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic nak);
    logic [7:0] junk;
    logic k1;
    logic k2;
    logic k3;
    q = 8'h00;
    sda_low = 1'b1;
    h();
    xfer({`PRCR_DEV_ADDR, 1'b0}, junk, k1);
    xfer(a, junk, k2);
    if (wr)
      xfer(d, junk, k3);
    else
    begin
      scl = 1'b0;
      h();
      sda_low = 1'b0;
      h();
      scl = 1'b1;
      h();
      sda_low = 1'b1;
      h();
      xfer({`PRCR_DEV_ADDR, 1'b1}, junk, k3);
      xfer(8'hFF, q, junk[0]);
    end
    scl = 1'b0;
    h();
    sda_low = 1'b1;
    h();
    scl = 1'b1;
    h();
    sda_low = 1'b0;
    h();
    nak = k1 | k2 | k3;
  endtask
endmodule
`default_nettype wire

// ---- prcr_rail_config_bench.sv ----
// self-checking bench for the rail config register bank
`timescale 1ns/1ps
`default_nettype none
module prcr_rail_config_bench;
  localparam int MS = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] pins = 6'h07;
  logic sl2 = 1'b0;
  logic sl3 = 1'b0;
  logic [2:0] rails = 3'h0;
  logic [2:0] duty = 3'h0;
  wire scl;
  wire sda_low;
  wire sda_out;
  wire sda_oe;
  wire [3:0] code2;
  wire [3:0] code3;
  wire [2:0] mode;
  wire [2:0] en;
  wire go1;
  wire go2;
  wire go4;
  int err_count = 0;
  int comparisons = 0;
  int ms_tab [8] = '{0, 5, 10, 15, 20, 50, 75, 100};
  int t1;
  int t2;
  int t4;
  // pulled-up data line, either party may pull it low
  wire sda_line = !sda_low && !(sda_oe && !sda_out);
  always #2.5 mclk = ~mclk;
  prcr_rail_config #(.MS_CYCLES(MS)) u_dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .rail_enable_inputs(pins), .ldo_two_sleep(sl2), .ldo_three_sleep(sl3),
    .rails_in_regulation(rails), .pg_duty(duty), .ldo_two_code(code2), .ldo_three_code(code3),
    .converter_mode(mode), .converter_enable(en), .general_output_one(go1), .general_output_two(go2),
    .general_output_four(go4));
  prcr_host u_host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic nak;
    u_host.access(1'b1, a, d, q, nak);
    check({15'h0, nak}, 16'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic nak;
    u_host.access(1'b0, a, 8'h00, q, nak);
    check({15'h0, nak}, 16'h0);
    check({8'h00, q}, {8'h00, exp});
  endtask
  // window allows one to four cycles of sync stages above the nominal count
  function automatic logic in_win(input int t, input int ms);
    return (t >= ms * MS + 1) && (t <= ms * MS + 4);
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (60000) @(posedge mclk);
    err_count = err_count + 1;
    complete_run();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    tick(5);
    rst_n = 1'b1;
    tick(4);
    check({2'h0, code2, code3, mode, en}, 16'h0);
    for (int i = 0; i < 5; i++)
      rd(8'h9A + i[7:0], 8'h00);
    wr(8'h9A, 8'hA5);
    rd(8'h9A, 8'hA5);
    check({12'h0, code2}, 16'h5);
    sl2 = 1'b1;
    tick(6);
    check({12'h0, code2}, 16'hA);
    wr(8'h9B, 8'h3C);
    rd(8'h9B, 8'h3C);
    sl3 = 1'b1;
    tick(6);
    check({12'h0, code3}, 16'h3);
    sl3 = 1'b0;
    tick(6);
    check({12'h0, code3}, 16'hC);
    wr(8'h9C, 8'hFF);
    rd(8'h9C, 8'h3F);
    // bit 5 always written as one, the only legal value
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h9C, {2'b00, 1'b1, i[1:0], i[2:0]});
      check({13'h0, mode}, {13'h0, 1'b1, i[1:0]});
      check({13'h0, en}, {13'h0, i[2:0]});
    end
    pins = 6'h05;
    tick(6);
    check({13'h0, en}, 16'h5);
    // all pins low: kill bits are all one, so only the pins can stop the converters
    pins = 6'h00;
    tick(6);
    check({13'h0, en}, 16'h0);
    duty = 3'h7;
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h9D, {c[2:0], c[2:0], c[1:0]});
      rails = 3'h7;
      t1 = 0;
      t2 = 0;
      t4 = 0;
      // counts low cycles; an output that never rises overruns the window
      for (int n = 0; n < 410; n++)
      begin
        tick(1);
        t1 = t1 + int'(go1 !== 1'b1);
        t2 = t2 + int'(go2 !== 1'b1);
        t4 = t4 + int'(go4 !== 1'b1);
      end
      check({15'h0, in_win(t2, ms_tab[c])}, 16'h1);
      check({15'h0, in_win(t4, ms_tab[c])}, 16'h1);
      check({15'h0, in_win(t1, ms_tab[c % 4])}, 16'h1);
      rails = 3'h0;
      tick(6);
      check({13'h0, go4, go2, go1}, 16'h0);
    end
    wr(8'h9D, 8'h00);
    duty = 3'h3;
    rails = 3'h7;
    tick(8);
    check({13'h0, go4, go2, go1}, 16'h3);
    duty = 3'h1;
    tick(6);
    check({13'h0, go4, go2, go1}, 16'h1);
    complete_run();
  end
endmodule
`default_nettype wire
